// ---- hdl/svlt_pkg.sv ----
// Purpose: Shared constants and carrier types for the servo axis loop block.
// Assumes: A single 10 MHz system clock.
// Notes:   Offsets are byte addresses on the register bus.
package svlt_pkg;

  // Clock and sample timing.
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned SAMPLE_1MS_NS  = 1000000;
  localparam int unsigned SAMPLE_1MS_CYC = (SAMPLE_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Arithmetic widths and scale constants.
  localparam int unsigned ACC_W          = 48;
  localparam int unsigned ILIM_MAX_V     = 319;
  localparam int unsigned MV_PER_V       = 1000;
  localparam int unsigned PERCENT_FULL   = 100;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_KP      = 8'h04;
  localparam logic [7:0] OFF_KI      = 8'h08;
  localparam logic [7:0] OFF_KD      = 8'h0c;
  localparam logic [7:0] OFF_VELOCITY_FEEDFORWARD_GAIN    = 8'h10;
  localparam logic [7:0] OFF_ILIM    = 8'h14;
  localparam logic [7:0] OFF_FERR    = 8'h18;
  localparam logic [7:0] OFF_IOCFG   = 8'h1c;
  localparam logic [7:0] OFF_STATUS  = 8'h20;
  localparam logic [7:0] OFF_LOOPOUT = 8'h24;

  // Control register fields.
  localparam int unsigned CTRL_DRIVE_EN   = 0;
  localparam int unsigned CTRL_INT_MOTION = 1;
  localparam int unsigned CTRL_SAMPLE_2MS = 2;
  localparam int unsigned CTRL_HOST_RUN   = 3;
  localparam int unsigned CTRL_TRIG_LSB   = 4;

  // I/O configuration fields.
  localparam int unsigned IO_POS_LIM_EN   = 0;
  localparam int unsigned IO_POS_OPEN     = 1;
  localparam int unsigned IO_NEG_LIM_EN   = 2;
  localparam int unsigned IO_NEG_OPEN     = 3;
  localparam int unsigned IO_FUNC_EN      = 4;

  // Status register fields.
  localparam int unsigned ST_RUNNING      = 0;
  localparam int unsigned ST_FEEDHOLD     = 1;
  localparam int unsigned ST_FERR_FAULT   = 2;
  localparam int unsigned ST_TRIG_SEEN    = 3;
  localparam int unsigned ST_POS_HIT      = 4;
  localparam int unsigned ST_NEG_HIT      = 5;
  localparam int unsigned ST_GP_LSB       = 8;

  // Reset values.
  localparam logic [31:0] RST_CTRL  = 32'h0000_0002;
  localparam logic [15:0] RST_GAIN  = 16'h0000;
  localparam logic [7:0]  RST_VELOCITY_FEEDFORWARD_GAIN  = 8'h64;
  localparam logic [8:0]  RST_ILIM  = 9'h00a;
  localparam logic [31:0] RST_FERR  = 32'h0000_1000;
  localparam logic [4:0]  RST_IOCFG = 5'h00;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    TRIG_EV1_RISE, TRIG_EV1_FALL, TRIG_EV1_HI_MARK, TRIG_EV1_LO_MARK,
    TRIG_MARK_RISE, TRIG_MARK_FALL, TRIG_EV2_RISE, TRIG_EV2_FALL
  } svlt_trig_e;

  // Pins from switches and the encoder, all asynchronous to aclk.
  typedef struct packed {
    logic event1;
    logic event2;
    logic marker;
    logic lim_pos;
    logic lim_neg;
    logic in_run;
    logic in_clear;
    logic in_feedhold;
  } svlt_pins_s;

endpackage

// ---- hdl/svlt_axis.sv ----
// Purpose: Per-axis position servo loop with trigger, limit and run inputs.
// Assumes: Error and velocities come from encoder logic on aclk.
// Notes:   Loop output is in millivolts, saturated to 32 bits signed.
`timescale 1ns/100ps
module svlt_axis
  import svlt_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_1MS_CYC
) (
  // Clock and reset.
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite slave.
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Encoder and profile data on aclk.
  input  wire logic signed [31:0] position_error,
  input  wire logic signed [31:0] velocity_meas,
  input  wire logic signed [31:0] velocity_cmd,
  input  wire logic               motion_active,
  // Asynchronous pins.
  input  svlt_pins_s              pins,
  // Loop and motion outputs.
  output logic signed [31:0]      loop_out,
  output logic                    trig_pulse,
  output logic                    pos_limit_hit,
  output logic                    neg_limit_hit,
  output logic                    program_run,
  output logic                    feedhold,
  output logic                    fast_stop,
  output logic                    ferr_fault
);

  function automatic logic [31:0] bmask(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return old;
  endfunction

  // Two-stage synchroniser for every pin.
  svlt_pins_s pin_m_reg, pin_s_reg, pin_d_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m_reg <= '0;
      pin_s_reg <= '0;
      pin_d_reg <= '0;
    end else begin
      pin_m_reg <= pins;
      pin_s_reg <= pin_m_reg;
      pin_d_reg <= pin_s_reg;
    end
  end

  // Software registers.
  logic [31:0] ctrl_reg, ferr_reg;
  logic [15:0] kp_reg, ki_reg, kd_reg;
  logic [7:0]  velocity_feedforward_gain_reg;
  logic [8:0]  ilim_reg;
  logic [4:0]  iocfg_reg;
  logic        host_run_reg, trig_seen_reg;
  wire         drive_en  = ctrl_reg[CTRL_DRIVE_EN];
  wire         sample_2m = ctrl_reg[CTRL_SAMPLE_2MS];
  wire         func_en   = iocfg_reg[IO_FUNC_EN];
  svlt_trig_e  trig_sel;
  assign trig_sel = svlt_trig_e'(ctrl_reg[CTRL_TRIG_LSB +: 3]);

  // AXI write channel.
  logic [7:0]  waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_have_reg, w_have_reg;
  wire         aw_take  = s_axi_awvalid && s_axi_awready;
  wire         w_take   = s_axi_wvalid && s_axi_wready;
  wire         do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire         wmapped  = (waddr_reg[1:0] == 2'b00) && (waddr_reg <= OFF_LOOPOUT);
  wire [31:0]  wnew     = bmask(32'h0, wdata_reg, wstrb_reg);
  wire         wr_ctrl  = do_write && waddr_reg == OFF_CTRL;
  wire         wr_stat  = do_write && waddr_reg == OFF_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      waddr_reg     <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
    end else begin
      if (aw_take) begin
        waddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_have_reg   <= (aw_have_reg || aw_take) && !do_write;
      w_have_reg    <= (w_have_reg || w_take) && !do_write;
      s_axi_awready <= !aw_have_reg && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_have_reg && !w_take && !s_axi_bvalid;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wmapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= RST_CTRL;
      kp_reg       <= RST_GAIN;
      ki_reg       <= RST_GAIN;
      kd_reg       <= RST_GAIN;
      velocity_feedforward_gain_reg     <= RST_VELOCITY_FEEDFORWARD_GAIN;
      ilim_reg     <= RST_ILIM;
      ferr_reg     <= RST_FERR;
      iocfg_reg    <= RST_IOCFG;
      host_run_reg <= 1'b0;
    end else begin
      host_run_reg <= wr_ctrl && wstrb_reg[0] && wdata_reg[CTRL_HOST_RUN];
      if (do_write) begin
        case (waddr_reg)
          OFF_CTRL:  ctrl_reg  <= bmask(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_0077;
          OFF_KP:    kp_reg    <= 16'(bmask({16'h0, kp_reg}, wdata_reg, wstrb_reg));
          OFF_KI:    ki_reg    <= 16'(bmask({16'h0, ki_reg}, wdata_reg, wstrb_reg));
          OFF_KD:    kd_reg    <= 16'(bmask({16'h0, kd_reg}, wdata_reg, wstrb_reg));
          OFF_VELOCITY_FEEDFORWARD_GAIN:  velocity_feedforward_gain_reg  <= 8'(bmask({24'h0, velocity_feedforward_gain_reg}, wdata_reg, wstrb_reg));
          OFF_ILIM:  ilim_reg  <= (wnew[15:0] > 16'(ILIM_MAX_V)) ? 9'(ILIM_MAX_V)
                                                                  : wnew[8:0];
          OFF_FERR:  ferr_reg  <= bmask(ferr_reg, wdata_reg, wstrb_reg);
          OFF_IOCFG: iocfg_reg <= 5'(bmask({27'h0, iocfg_reg}, wdata_reg, wstrb_reg));
          default:   ;
        endcase
      end
    end
  end

  // Sample tick every 1 or 2 ms.
  logic [$clog2(2*SAMPLE_CYC)-1:0] tick_cnt_reg;
  wire  tick = (tick_cnt_reg == ($bits(tick_cnt_reg))'(sample_2m ? 2*SAMPLE_CYC - 1
                                                                   : SAMPLE_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // Loop terms, all in millivolts.
  wire signed [ACC_W-1:0] err_x  = ACC_W'(position_error);
  wire signed [ACC_W-1:0] p_term = ACC_W'(err_x * $signed({1'b0, kp_reg}));
  wire signed [ACC_W-1:0] ilim_mv = ACC_W'(ilim_reg) * ACC_W'(MV_PER_V);
  wire signed [ACC_W-1:0] ff_raw = ACC_W'(ACC_W'(velocity_cmd) * $signed({1'b0, velocity_feedforward_gain_reg}));
  wire signed [ACC_W-1:0] ff_term = ACC_W'((ff_raw / $signed(ACC_W'(PERCENT_FULL)))
                                           * $signed({1'b0, kd_reg}));
  wire signed [ACC_W-1:0] v_term = ACC_W'(ACC_W'(velocity_meas) * $signed({1'b0, kd_reg}));
  logic signed [ACC_W-1:0] integ_reg;
  logic [15:0] ki_ms_reg;
  wire  [15:0] ki_step = ki_ms_reg + (sample_2m ? 16'h0002 : 16'h0001);
  wire         ki_hit  = ki_step >= ki_reg;
  wire signed [ACC_W-1:0] i_sum = integ_reg + p_term;
  wire signed [ACC_W-1:0] i_clamp = (i_sum > ilim_mv) ? ilim_mv
                                  : (i_sum < -ilim_mv) ? -ilim_mv : i_sum;
  // A lowered limit takes effect at once, not only at the next integration step.
  wire signed [ACC_W-1:0] i_hold = (integ_reg > ilim_mv) ? ilim_mv
                                 : (integ_reg < -ilim_mv) ? -ilim_mv : integ_reg;
  wire signed [ACC_W-1:0] i_use = (ctrl_reg[CTRL_INT_MOTION] || !motion_active)
                                  ? integ_reg : '0;
  wire signed [ACC_W-1:0] total = p_term + i_use + ff_term - v_term;
  wire signed [31:0] total_sat = (total > ACC_W'(32'sh7fff_ffff)) ? 32'sh7fff_ffff
                               : (total < -ACC_W'(32'sh7fff_ffff)) ? -32'sh7fff_ffff
                               : 32'(total);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      integ_reg <= '0;
      ki_ms_reg <= '0;
      loop_out  <= '0;
    end else begin
      if (!drive_en || ki_reg == 16'h0) begin
        integ_reg <= '0;
        ki_ms_reg <= '0;
      end else if (tick) begin
        ki_ms_reg <= ki_hit ? 16'h0 : ki_step;
        integ_reg <= ki_hit ? i_clamp : i_hold;
      end else begin
        integ_reg <= i_hold;
      end
      if (tick) begin
        loop_out <= total_sat;
      end
    end
  end

  // Following error check and limits.
  wire [31:0] err_abs = position_error[31] ? 32'(-position_error) : 32'(position_error);
  wire ferr_over = motion_active && (err_abs > ferr_reg);
  wire pos_lvl   = pin_s_reg.lim_pos ^ iocfg_reg[IO_POS_OPEN];
  wire neg_lvl   = pin_s_reg.lim_neg ^ iocfg_reg[IO_NEG_OPEN];

  // Trigger selection.
  wire ev1_r = pin_s_reg.event1 && !pin_d_reg.event1;
  wire ev1_f = !pin_s_reg.event1 && pin_d_reg.event1;
  wire ev2_r = pin_s_reg.event2 && !pin_d_reg.event2;
  wire ev2_f = !pin_s_reg.event2 && pin_d_reg.event2;
  wire mk_r  = pin_s_reg.marker && !pin_d_reg.marker;
  wire mk_f  = !pin_s_reg.marker && pin_d_reg.marker;
  logic trig_hit;
  always_comb begin
    case (trig_sel)
      TRIG_EV1_RISE:    trig_hit = ev1_r;
      TRIG_EV1_FALL:    trig_hit = ev1_f;
      TRIG_EV1_HI_MARK: trig_hit = pin_s_reg.event1 && pin_s_reg.marker;
      TRIG_EV1_LO_MARK: trig_hit = !pin_s_reg.event1 && pin_s_reg.marker;
      TRIG_MARK_RISE:   trig_hit = mk_r;
      TRIG_MARK_FALL:   trig_hit = mk_f;
      TRIG_EV2_RISE:    trig_hit = ev2_r;
      TRIG_EV2_FALL:    trig_hit = ev2_f;
      default:          trig_hit = 1'b0;
    endcase
  end

  // Run, clear and feedhold; a high clear pin (floating) means clear is active when IO_FUNC_EN is set.
  wire clear_fn = func_en && pin_s_reg.in_clear;
  wire run_act  = func_en && pin_s_reg.in_run;
  wire run_rise = run_act && !pin_d_reg.in_run;
  wire fh_act   = func_en && pin_s_reg.in_feedhold;
  logic powered_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powered_reg   <= 1'b0;
      program_run   <= 1'b0;
      feedhold      <= 1'b0;
      fast_stop     <= 1'b0;
      ferr_fault    <= 1'b0;
      trig_pulse    <= 1'b0;
      trig_seen_reg <= 1'b0;
      pos_limit_hit <= 1'b0;
      neg_limit_hit <= 1'b0;
    end else begin
      powered_reg   <= 1'b1;
      trig_pulse    <= trig_hit;
      pos_limit_hit <= iocfg_reg[IO_POS_LIM_EN] && pos_lvl;
      neg_limit_hit <= iocfg_reg[IO_NEG_LIM_EN] && neg_lvl;
      trig_seen_reg <= trig_hit || (trig_seen_reg && !(wr_stat && wnew[ST_TRIG_SEEN]));
      ferr_fault    <= ferr_over || (ferr_fault && !(wr_stat && wnew[ST_FERR_FAULT]));
      fast_stop     <= clear_fn && motion_active;
      if (clear_fn) begin
        program_run <= 1'b0;
        feedhold    <= 1'b0;
      end else if (!powered_reg) begin
        program_run <= run_act;
      end else begin
        if (fh_act) begin
          feedhold <= 1'b1;
        end else if (run_rise && feedhold) begin
          feedhold <= 1'b0;
        end
        if (host_run_reg || (run_rise && !feedhold)) begin
          program_run <= 1'b1;
        end
      end
    end
  end

  // Register read channel.
  wire [31:0] status_word = {16'h0, 5'h0, pin_s_reg.in_feedhold, pin_s_reg.in_clear,
                             pin_s_reg.in_run, 2'b00, neg_limit_hit, pos_limit_hit,
                             trig_seen_reg, ferr_fault, feedhold, program_run};
  logic [31:0] rmux;
  always_comb begin
    case (s_axi_araddr)
      OFF_CTRL:    rmux = ctrl_reg;
      OFF_KP:      rmux = {16'h0, kp_reg};
      OFF_KI:      rmux = {16'h0, ki_reg};
      OFF_KD:      rmux = {16'h0, kd_reg};
      OFF_VELOCITY_FEEDFORWARD_GAIN:    rmux = {24'h0, velocity_feedforward_gain_reg};
      OFF_ILIM:    rmux = {23'h0, ilim_reg};
      OFF_FERR:    rmux = ferr_reg;
      OFF_IOCFG:   rmux = {27'h0, iocfg_reg};
      OFF_STATUS:  rmux = status_word;
      OFF_LOOPOUT: rmux = loop_out;
      default:     rmux = 32'h0;
    endcase
  end
  wire rmapped = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= OFF_LOOPOUT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rmux;
      s_axi_rresp   <= rmapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ki_zero;  (ki_reg == 16'h0) |=> (integ_reg == '0); endproperty
  a_ki_zero:  assert property (p_ki_zero) else $error("integral not zero at zero gain");
  property p_drv_off;  !drive_en |=> (integ_reg == '0); endproperty
  a_drv_off:  assert property (p_drv_off) else $error("integral kept while drive off");
  property p_ilim;     ##1 (integ_reg <= $past(ilim_mv) && integ_reg >= -$past(ilim_mv));
  endproperty
  a_ilim:     assert property (p_ilim) else $error("integral beyond limit");
  property p_hold;     !$past(tick) |-> $stable(loop_out); endproperty
  a_hold:     assert property (p_hold) else $error("loop output moved off tick");
  property p_space;    tick |=> !tick [*8]; endproperty
  a_space:    assert property (p_space) else $error("sample ticks too close");
  property p_ferr;     ferr_over |=> ferr_fault; endproperty
  a_ferr:     assert property (p_ferr) else $error("following fault missed");
  property p_clear;    clear_fn |=> !program_run && !feedhold; endproperty
  a_clear:    assert property (p_clear) else $error("clear did not stop program");
  property p_fh;       (fh_act && !clear_fn && powered_reg) |=> feedhold; endproperty
  a_fh:       assert property (p_fh) else $error("feedhold not set");
  property p_comb;     (trig_sel == TRIG_EV1_HI_MARK && !(pin_s_reg.event1 && pin_s_reg.marker))
                       |=> !trig_pulse; endproperty
  a_comb:     assert property (p_comb) else $error("combined trigger fired alone");
  property p_edge;     (trig_sel == TRIG_EV2_RISE && ev2_r) |=> trig_pulse; endproperty
  a_edge:     assert property (p_edge) else $error("event two edge missed");
  property p_lim;      !iocfg_reg[IO_POS_LIM_EN] |=> !pos_limit_hit; endproperty
  a_lim:      assert property (p_lim) else $error("limit active while general input");

  c_trig:  cover property (trig_pulse);
  c_fh:    cover property (feedhold ##[1:20] !feedhold);
  c_clamp: cover property (tick && ki_hit && (i_clamp != i_sum));
  c_wr:    cover property (s_axi_bvalid && s_axi_bready);

endmodule // svlt_axis

// ---- bench/svlt_far_model.sv ----
// Purpose: Far-side model of the encoder error source and the switch wiring.
// Assumes: The error ramps one count every 16 clocks when asked, under 1M counts/s.
// Notes:   Pins settle 37 ns after a command, off the clock edge.
`timescale 1ns/100ps
module svlt_far_model
  import svlt_pkg::*;
(
  // Clock.
  input  wire logic               aclk,
  // Commands from the bench.
  input  wire logic               ramp,
  input  wire logic signed [31:0] err_set,
  input  svlt_pins_s              pins_cmd,
  // Lines into the axis.
  output logic signed [31:0]      position_error,
  output svlt_pins_s              pins
);
  logic [3:0] div_reg = 4'h0;

  assign #37 pins = pins_cmd;

  always_ff @(posedge aclk) begin
    div_reg <= div_reg + 4'h1;
    if (!ramp)
      position_error <= err_set;
    else if (div_reg == 4'hf)
      position_error <= position_error + 32'sd1;
  end
endmodule // svlt_far_model

// ---- bench/svlt_axis_tb_top.sv ----
// Purpose: Self-checking bench for the servo axis loop block.
// Assumes: A short sample period of 20 clocks.
// Notes:   Random gains and velocities come from a fixed-seed xorshift.
`timescale 1ns/100ps
module svlt_axis_tb_top
  import svlt_pkg::*;
;
  localparam int unsigned SC = 20;
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic [7:0]         awaddr = '0, araddr = '0;
  logic [31:0]        wdata = '0, rdata, rv, kp, kd, kv, ov, seen;
  logic               awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp, resp;
  logic signed [31:0] perr, lout, vmeas = '0, vcmd = '0, eset = '0;
  logic               motion = 1'b0, ramp = 1'b0;
  logic               trig, plim, nlim, prun, fhold, fstop, ffault;
  svlt_pins_s         pcmd = '0, pins;
  logic [31:0]        seed = 32'he812;
  int                 fails = 0, tests_run = 0, n;
  logic [7:0]         ts [8] = '{8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h20, 8'h00, 8'h40};
  logic [7:0]         te [8] = '{8'h80, 8'h00, 8'ha0, 8'h20, 8'h20, 8'h00, 8'h40, 8'h00};
  logic [31:0]        lc [3] = '{32'h0, 32'h5, 32'hf};
  logic [31:0]        le [3] = '{32'h0, 32'h2, 32'h1};

  always #50 aclk = ~aclk;

  svlt_far_model far (.aclk(aclk), .ramp(ramp), .err_set(eset), .pins_cmd(pcmd),
    .position_error(perr), .pins(pins));

  svlt_axis #(.SAMPLE_CYC(SC)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .position_error(perr),
    .velocity_meas(vmeas), .velocity_cmd(vcmd), .motion_active(motion), .pins(pins),
    .loop_out(lout), .trig_pulse(trig), .pos_limit_hit(plim), .neg_limit_hit(nlim),
    .program_run(prun), .feedhold(fhold), .fast_stop(fstop), .ferr_fault(ffault));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] vel_exp(int k, int c, int v, int f);
    return k * (c * f / 100) - k * v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && k < 50);
    if (k >= 50) begin
      fails++;
      print_verdict();
    end
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && k < 50);
    if (k >= 50) begin
      fails++;
      print_verdict();
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  initial begin
    repeat (100000) @(posedge aclk);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_CTRL, rv);
    chk(rv, RST_CTRL);
    rd(OFF_VELOCITY_FEEDFORWARD_GAIN, rv);
    chk(rv, {24'h0, RST_VELOCITY_FEEDFORWARD_GAIN});
    rd(OFF_FERR, rv);
    chk(rv, RST_FERR);
    rd(8'h28, rv);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(8'h28, 32'h0);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFF_ILIM, 32'h190);
    rd(OFF_ILIM, rv);
    chk(rv, 32'd319);
    wr(OFF_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      kp = rnd() & 32'hff;
      eset <= $signed(rnd() & 32'hfff) - 32'sd2048;
      wr(OFF_KP, kp);
      repeat (2 * SC + 2) @(posedge aclk);
      chk(lout, eset * kp);
    end
    wr(OFF_KP, 32'h0);
    for (int i = 0; i < 3; i++) begin
      kd = rnd() & 32'hff;
      kv = rnd() & 32'h7f;
      vmeas <= rnd() & 32'h3ff;
      vcmd <= rnd() & 32'h3ff;
      wr(OFF_KD, kd);
      wr(OFF_VELOCITY_FEEDFORWARD_GAIN, kv);
      repeat (2 * SC + 2) @(posedge aclk);
      chk(lout, vel_exp(kd, vcmd, vmeas, kv));
    end
    wr(OFF_KD, 32'h0);
    eset <= 32'sd1000;
    wr(OFF_KP, 32'h1);
    wr(OFF_ILIM, 32'h1);
    wr(OFF_KI, 32'h1);
    repeat (8 * SC) @(posedge aclk);
    chk(lout, 32'd2000);
    motion <= 1'b1;
    wr(OFF_CTRL, 32'h1);
    repeat (2 * SC + 2) @(posedge aclk);
    chk(lout, 32'd1000);
    motion <= 1'b0;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_KI, 32'd1000);
    repeat (2 * SC) @(posedge aclk);
    wr(OFF_CTRL, 32'h3);
    repeat (2 * SC + 2) @(posedge aclk);
    chk(lout, 32'd1000);
    wr(OFF_KI, 32'h0);
    ramp <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      wr(OFF_CTRL, 32'h3 | (m << 2));
      for (int k = 0; k < 3; k++) begin
        ov = lout;
        n = 0;
        do begin
          @(posedge aclk);
          n++;
        end while (lout === ov && n < 100);
        if (n >= 100) begin
          fails++;
          print_verdict();
        end
      end
      chk(n, SC * (m + 1));
    end
    ramp <= 1'b0;
    motion <= 1'b1;
    eset <= 32'sh1000;
    repeat (10) @(posedge aclk);
    chk({31'h0, ffault}, 32'h0);
    eset <= 32'sh1001;
    repeat (10) @(posedge aclk);
    chk({31'h0, ffault}, 32'h1);
    rd(OFF_STATUS, rv);
    chk(rv, 32'h1 << ST_FERR_FAULT);
    motion <= 1'b0;
    wr(OFF_STATUS, 32'h1 << ST_FERR_FAULT);
    chk({31'h0, ffault}, 32'h0);
    for (int s = 0; s < 8; s++) begin
      wr(OFF_CTRL, 32'h3 | (s << 4));
      pcmd <= svlt_pins_s'(ts[s]);
      repeat (8) @(posedge aclk);
      chk({31'h0, trig}, 32'h0);
      pcmd <= svlt_pins_s'(te[s]);
      seen = 0;
      repeat (8) begin
        @(posedge aclk);
        seen = seen | trig;
      end
      chk(seen, 32'h1);
    end
    for (int c = 0; c < 3; c++) begin
      wr(OFF_IOCFG, lc[c]);
      pcmd <= svlt_pins_s'(8'h10);
      repeat (8) @(posedge aclk);
      chk({30'h0, plim, nlim}, le[c]);
    end
    wr(OFF_IOCFG, 32'h10);
    pcmd <= svlt_pins_s'(8'h01);
    repeat (8) @(posedge aclk);
    chk({31'h0, fhold}, 32'h1);
    pcmd <= svlt_pins_s'(8'h04);
    repeat (8) @(posedge aclk);
    chk({31'h0, fhold}, 32'h0);
    pcmd <= svlt_pins_s'(8'h00);
    repeat (8) @(posedge aclk);
    pcmd <= svlt_pins_s'(8'h04);
    repeat (8) @(posedge aclk);
    chk({31'h0, prun}, 32'h1);
    motion <= 1'b1;
    pcmd <= svlt_pins_s'(8'h06);
    repeat (8) @(posedge aclk);
    chk({30'h0, prun, fstop}, 32'h1);
    pcmd <= svlt_pins_s'(8'h03);
    wr(OFF_CTRL, 32'hb);
    repeat (8) @(posedge aclk);
    chk({30'h0, prun, fhold}, 32'h0);
    pcmd <= svlt_pins_s'(8'h00);
    motion <= 1'b0;
    repeat (8) @(posedge aclk);
    wr(OFF_CTRL, 32'hb);
    repeat (4) @(posedge aclk);
    chk({31'h0, prun}, 32'h1);
    print_verdict();
  end
endmodule // svlt_axis_tb_top
